// ===== rtl/pmi_pkg.sv
package pmi_pkg;

  // ---------------------------------------------------------------
  // Clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BIT_CLOCK_HZ = 250_000;
  // Half period of the memory bit clock, rounded down
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_CLOCK_HZ);
  localparam int READ_CYCLE_US = 200;
  // Least duration of a read cycle, rounded up
  localparam int READ_CYCLE_CYC = (READ_CYCLE_US * (CLK_HZ / 1000) + 999)
                                  / 1000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_TIMEOUT_CYC = PROG_TIME_MS * (CLK_HZ / 1000);
  // Cycles after select rises before the ready level is trusted
  localparam int POLL_SETTLE_CYC = 4;

  // ---------------------------------------------------------------
  // Memory command layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int WORD_W = 16;
  localparam int CMD_W = 9;
  localparam int FRAME_W = CMD_W + WORD_W;
  localparam int SR_BITS = 24;
  localparam logic [2:0] OP_READ = 3'h6;
  localparam logic [2:0] OP_EWEN = 3'h4;
  localparam logic [2:0] OP_WRITE = 3'h5;
  localparam logic [5:0] ADR_EWEN = 6'h30;
  localparam logic [5:0] ADR_WORD0 = 6'h00;
  localparam logic [6:0] BAD_STATION = 7'h7E;

  // ---------------------------------------------------------------
  // Pin positions on the station-address pins
  // ---------------------------------------------------------------
  localparam int PIN_DI = 1;
  localparam int PIN_ACA = 5;
  localparam int PIN_TYPE = 6;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_WDATA = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_RDATA = 3'h3;
  localparam int CTRL_RD = 0;
  localparam int CTRL_WRCALL = 1;
  localparam int CTRL_WADDR = 2;
  localparam int CTRL_NOCHG = 3;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [6:0] STATION_RST = 7'h00;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LOAD  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_GAP   = 5'h08,
    ST_POLL  = 5'h10
  } pmi_state_type;

  typedef enum logic [3:0] {
    PH_EWEN  = 4'h1,
    PH_WRITE = 4'h2,
    PH_READ  = 4'h4,
    PH_SR    = 4'h8
  } pmi_phase_type;

endpackage : pmi_pkg

// ===== rtl/pmi_param_memory.sv
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

module pmi_param_memory #(
  parameter int PROG_TIMEOUT = pmi_pkg::PROG_TIMEOUT_CYC
) (
  input wire logic mclk, // System clock
  input wire logic nrst, // Asynchronous reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic serial_param_select, // Pin: serial memory used
  input wire logic [6:0] station_address_pins, // Pin inputs
  output logic param_memory_select, // Memory select level
  output logic param_memory_select_oe, // Drives pin when high
  output logic param_serial_clock, // Memory bit clock
  output logic param_serial_clock_oe, // Drives pin when high
  output logic param_serial_out, // Data out or parallel load
  output logic param_serial_out_oe, // Drives pin when high
  input wire logic [2:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, one cycle later
  input wire logic telegram_error_free, // Telegram passed checks
  output logic [6:0] station_address, // Current station address
  output logic call_ack, // Write call acknowledge pulse
  output logic baud_search_restart, // Pulse after acknowledge
  output logic negative_ack_response // Write call refused pulse
);
  import pmi_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam logic [5:0] HALF_LAST = 6'(HALF_BIT_CYC - 1);
  localparam logic [12:0] READ_MIN = 13'(READ_CYCLE_CYC);
  localparam logic [4:0] CMD_BITS = 5'(CMD_W);
  localparam logic [4:0] FRAME_BITS = 5'(FRAME_W);
  localparam logic [4:0] SR_COUNT = 5'(SR_BITS);
  localparam int TW = $clog2(PROG_TIMEOUT + 1);
  localparam int AST_HALF = HALF_BIT_CYC;

  logic sel_m_ff, sel_s_ff;
  logic [6:0] pins_m_ff, pins_s_ff;
  logic di_s, aca_s, ee_s;
  pmi_state_type state_ff;
  pmi_phase_type phase_ff;
  logic [5:0] div_ff;
  logic tick;
  logic [4:0] bits_ff;
  logic [FRAME_W-1:0] tx_ff;
  logic [SR_BITS-1:0] rx_ff;
  logic cs_ff, sclk_ff, dout_ff;
  logic [12:0] cyc_ff;
  logic [TW-1:0] prog_ff;
  logic prog_timeout_ff;
  logic rd_flag_ff, wr_flag_ff;
  logic waddr_ff, nochg_ff, poweron_ff;
  logic [15:0] wdata_ff, rdata_ff;
  logic [6:0] station_ff;
  logic ack_ff, restart_ff, nak_ff;
  logic ctrl_wr, call, mem_ok, allowed;
  logic rd_done, wr_done;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst || !clk_en);

  // Convert a two-digit BCD address, illegal codes map to 126
  function automatic logic [6:0] bcd_to_bin(input logic [7:0] b);
    logic [6:0] tens;
    tens = {3'h0, b[7:4]};
    if (b[7:4] > 4'h9 || b[3:0] > 4'h9 || b == 8'h00) begin
      return BAD_STATION;
    end
    return 7'(tens * 7'h0A + {3'h0, b[3:0]});
  endfunction : bcd_to_bin

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Strap and serial inputs come from off chip
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_m_ff <= 1'b0;
      sel_s_ff <= 1'b0;
      pins_m_ff <= 7'h00;
      pins_s_ff <= 7'h00;
    end else if (clk_en) begin
      sel_m_ff <= serial_param_select;
      sel_s_ff <= sel_m_ff;
      pins_m_ff <= station_address_pins;
      pins_s_ff <= pins_m_ff;
    end
  end

  // Repurposed pin meanings in serial mode
  assign di_s = pins_s_ff[PIN_DI];
  assign aca_s = pins_s_ff[PIN_ACA] & ee_s;
  assign ee_s = pins_s_ff[PIN_TYPE];

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  assign ctrl_wr = reg_wr && reg_addr == REG_CTRL;
  assign call = ctrl_wr && reg_wdata[CTRL_WRCALL];
  // Only an attached EEPROM can take an address write
  assign mem_ok = sel_s_ff && ee_s;
  assign allowed = poweron_ff || aca_s || !nochg_ff;

  // Control bits written through the control register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waddr_ff <= 1'b0;
      nochg_ff <= 1'b0;
    end else if (clk_en && ctrl_wr) begin
      waddr_ff <= reg_wdata[CTRL_WADDR];
      nochg_ff <= reg_wdata[CTRL_NOCHG];
    end
  end

  // Held off while a write runs so the frame cannot change under it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdata_ff <= WDATA_RST;
    end else if (clk_en && reg_wr && reg_addr == REG_WDATA &&
                 telegram_error_free && !wr_flag_ff) begin
      wdata_ff <= reg_wdata;
    end
  end

  // Call answers: acknowledge first, baud restart one cycle later
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      restart_ff <= 1'b0;
      nak_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= call && mem_ok;
      restart_ff <= ack_ff;
      nak_ff <= call && !mem_ok;
    end
  end

  // Request flags, a new request wins over a same-cycle clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_flag_ff <= 1'b0;
      wr_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (rd_done) begin
        rd_flag_ff <= 1'b0;
      end
      if (ctrl_wr && reg_wdata[CTRL_RD] && sel_s_ff) begin
        rd_flag_ff <= 1'b1;
      end
      if (wr_done) begin
        wr_flag_ff <= 1'b0;
      end
      if (call && mem_ok && allowed) begin
        wr_flag_ff <= 1'b1;
      end
    end
  end

  // Power-on grant lasts until the first address write lands
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      poweron_ff <= 1'b1;
    end else if (clk_en && wr_done) begin
      poweron_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bit clock divider
  // ---------------------------------------------------------------
  // Runs only while a cycle is active so each cycle starts aligned
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 6'h00;
    end else if (clk_en) begin
      if (state_ff == ST_IDLE || tick) begin
        div_ff <= 6'h00;
      end else begin
        div_ff <= div_ff + 6'h01;
      end
    end
  end
  assign tick = state_ff != ST_IDLE && div_ff == HALF_LAST;

  // Elapsed time of the current cycle, saturating
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cyc_ff <= 13'h0000;
    end else if (clk_en) begin
      if (state_ff == ST_IDLE) begin
        cyc_ff <= 13'h0000;
      end else if (cyc_ff != READ_MIN) begin
        cyc_ff <= cyc_ff + 13'h0001;
      end
    end
  end

  // Completion strobes for the flag logic
  assign rd_done = (state_ff == ST_GAP && phase_ff == PH_READ &&
                    cyc_ff == READ_MIN) ||
                   (state_ff == ST_SHIFT && phase_ff == PH_SR && tick &&
                    sclk_ff && bits_ff == 5'h00);
  // Stale line level must clear the synchroniser before ready counts
  assign wr_done = state_ff == ST_POLL && di_s &&
                   prog_ff >= TW'(POLL_SETTLE_CYC);

  // ---------------------------------------------------------------
  // Memory sequencer
  // ---------------------------------------------------------------
  // One frame per command; the write path always runs the enable
  // frame first and never sends an erase
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_READ;
      bits_ff <= 5'h00;
      tx_ff <= '0;
      cs_ff <= 1'b0;
      sclk_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else if (clk_en) begin
      unique case (state_ff)
        ST_IDLE: begin
          sclk_ff <= 1'b0;
          // Shift-register idles with clock disabled and load high
          cs_ff <= !ee_s;
          dout_ff <= !ee_s;
          if (sel_s_ff && !ee_s && rd_flag_ff) begin
            phase_ff <= PH_SR;
            state_ff <= ST_LOAD;
            cs_ff <= 1'b1;
            dout_ff <= 1'b0;
          end else if (mem_ok && rd_flag_ff) begin
            phase_ff <= PH_READ;
            state_ff <= ST_SHIFT;
            bits_ff <= FRAME_BITS;
            cs_ff <= 1'b1;
            dout_ff <= 1'b1;
            tx_ff <= {OP_READ[1:0], 5'h00, waddr_ff,
                      17'h00000};
          end else if (mem_ok && wr_flag_ff) begin
            phase_ff <= PH_EWEN;
            state_ff <= ST_SHIFT;
            bits_ff <= CMD_BITS;
            cs_ff <= 1'b1;
            dout_ff <= 1'b1;
            tx_ff <= {OP_EWEN[1:0], ADR_EWEN, 17'h00000};
          end
        end
        ST_LOAD: begin
          // Parallel load low for one half bit, then shift enabled
          if (tick) begin
            tx_ff <= '1; // Keeps the load line high while shifting
            dout_ff <= 1'b1;
            cs_ff <= 1'b0;
            bits_ff <= SR_COUNT;
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            if (!sclk_ff) begin
              sclk_ff <= 1'b1;
              bits_ff <= bits_ff - 5'h01;
            end else begin
              sclk_ff <= 1'b0;
              if (bits_ff != 5'h00) begin
                dout_ff <= tx_ff[FRAME_W-1];
                tx_ff <= {tx_ff[FRAME_W-2:0], 1'b0};
              end else if (phase_ff == PH_SR) begin
                cs_ff <= 1'b1;
                state_ff <= ST_IDLE;
              end else begin
                cs_ff <= 1'b0;
                dout_ff <= 1'b0;
                state_ff <= ST_GAP;
              end
            end
          end
        end
        ST_GAP: begin
          // Select low between frames; reads also honour least time
          if (tick || phase_ff == PH_READ) begin
            unique case (phase_ff)
              PH_EWEN: begin
                phase_ff <= PH_WRITE;
                state_ff <= ST_SHIFT;
                bits_ff <= FRAME_BITS;
                cs_ff <= 1'b1;
                dout_ff <= 1'b1;
                tx_ff <= {OP_WRITE[1:0], ADR_WORD0,
                          wdata_ff, 1'b0};
              end
              PH_WRITE: begin
                cs_ff <= 1'b1;
                state_ff <= ST_POLL;
              end
              default: begin
                if (cyc_ff == READ_MIN) begin
                  state_ff <= ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_POLL: begin
          // Ready on the serial input ends programming
          if (wr_done) begin
            cs_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive shift: MSB first from EEPROM, LSB first from register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_ff <= '0;
    end else if (clk_en) begin
      if (state_ff == ST_IDLE) begin
        rx_ff <= '0;
      end else if (state_ff == ST_SHIFT && tick && !sclk_ff) begin
        if (phase_ff == PH_SR) begin
          rx_ff <= {di_s, rx_ff[SR_BITS-1:1]};
        end else begin
          rx_ff <= {rx_ff[SR_BITS-2:0], di_s};
        end
      end
    end
  end

  // Programming watchdog; the write flag still waits for ready
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prog_ff <= '0;
      prog_timeout_ff <= 1'b0;
    end else if (clk_en) begin
      if (call) begin
        prog_timeout_ff <= 1'b0;
      end
      if (state_ff != ST_POLL) begin
        prog_ff <= '0;
      end else if (prog_ff == TW'(PROG_TIMEOUT)) begin
        prog_timeout_ff <= 1'b1;
      end else begin
        prog_ff <= prog_ff + TW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Read results and station address
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= RDATA_RST;
      station_ff <= STATION_RST;
    end else if (clk_en) begin
      if (!sel_s_ff) begin
        station_ff <= pins_s_ff;
      end else if (rd_done && phase_ff == PH_SR) begin
        rdata_ff <= rx_ff[SR_BITS-1:8];
        station_ff <= bcd_to_bin(rx_ff[7:0]);
      end else if (rd_done) begin
        rdata_ff <= rx_ff[WORD_W-1:0];
        if (!waddr_ff) begin
          station_ff <= rx_ff[ADDR_W-1:0];
        end
      end else if (wr_done) begin
        station_ff <= wdata_ff[ADDR_W-1:0];
      end
    end
  end

  // Register read port, data only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_CTRL: reg_rdata <= {12'h000, nochg_ff, waddr_ff, 2'h0};
          REG_WDATA: reg_rdata <= wdata_ff;
          REG_STATUS: reg_rdata <= {1'b0, station_ff, 2'h0,
                                    poweron_ff, prog_timeout_ff,
                                    sel_s_ff, ee_s, wr_flag_ff,
                                    rd_flag_ff};
          REG_RDATA: reg_rdata <= rdata_ff;
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Serial pins only driven when the straps select serial mode
  assign param_memory_select = cs_ff;
  assign param_serial_clock = sclk_ff;
  assign param_serial_out = dout_ff;
  assign param_memory_select_oe = sel_s_ff;
  assign param_serial_clock_oe = sel_s_ff;
  assign param_serial_out_oe = sel_s_ff;
  assign station_address = station_ff;
  assign call_ack = ack_ff;
  assign baud_search_restart = restart_ff;
  assign negative_ack_response = nak_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_call_ok;
    call && mem_ok;
  endsequence
  sequence s_ack_then_restart;
    ##1 call_ack ##1 (baud_search_restart && !call_ack);
  endsequence

  AST_PARALLEL_ADDR: assert property (
    !sel_s_ff |=> station_address == $past(pins_s_ff))
    else $error("parallel address not taken from pins");
  AST_EE_IDLE_LOW: assert property (
    state_ff == ST_IDLE && $past(state_ff) == ST_IDLE && ee_s &&
    $past(ee_s) |-> !cs_ff && !sclk_ff && !dout_ff)
    else $error("EEPROM idle outputs not low");
  AST_ACK_ORDER: assert property (
    s_call_ok |-> s_ack_then_restart)
    else $error("acknowledge and baud restart out of order");
  AST_NAK: assert property (
    call && !mem_ok |=> negative_ack_response && !call_ack)
    else $error("missing negative acknowledge");
  AST_EWEN_FIRST: assert property (
    state_ff == ST_IDLE && mem_ok && wr_flag_ff && !rd_flag_ff
    |=> state_ff == ST_SHIFT && phase_ff == PH_EWEN && dout_ff &&
        tx_ff[FRAME_W-1:FRAME_W-8] == {OP_EWEN[1:0], ADR_EWEN})
    else $error("write not preceded by enable");
  AST_WRITE_ADDR0: assert property (
    $rose(phase_ff == PH_WRITE)
    |-> tx_ff[FRAME_W-1:FRAME_W-8] == {OP_WRITE[1:0], ADR_WORD0})
    else $error("write command pattern wrong");
  AST_WR_CLEAR: assert property (
    $fell(wr_flag_ff) |-> $past(state_ff == ST_POLL && di_s))
    else $error("write flag cleared before ready");
  AST_RD_RESULT: assert property (
    $fell(rd_flag_ff) && phase_ff == PH_READ
    |-> rdata_ff == $past(rx_ff[WORD_W-1:0]))
    else $error("read word not captured at flag clear");
  AST_HALF_BIT: assert property (
    $rose(sclk_ff) |-> ##AST_HALF $fell(sclk_ff))
    else $error("bit clock high time wrong");
  AST_SHIFT_ON_FALL: assert property (
    $changed(dout_ff) && state_ff == ST_SHIFT && $past(state_ff) ==
    ST_SHIFT |-> !sclk_ff && $past(sclk_ff))
    else $error("data changed away from falling clock");

endmodule : pmi_param_memory

// ===== tb/pmi_eeprom_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Serial word memory on the far side of the parameter port
// ------------------------------------------------------------
module pmi_eeprom_model (
  input wire logic cs, // Select, high active
  input wire logic sclk, // Bit clock from the block
  input wire logic din, // Command and data from the block
  output logic dout, // Read data or ready level
  output logic sr_q // Shift register serial output
);
  logic [15:0] mem [2];
  logic [15:0] sh;
  logic [8:0] cmd;
  logic [8:0] cmd_log [$];
  logic en;
  logic busy;
  int n;
  logic [23:0] sr;
  // ID half arbitrary; low byte is BCD station address 37
  localparam logic [23:0] SR_WORD = 24'h123437;

  // Known contents so read data can be told apart
  initial begin
    mem[0] = 16'hA5C3;
    mem[1] = 16'h3C5A;
    en = 1'b0;
    busy = 1'b0;
    dout = 1'b0;
    n = 0;
  end

  // Rising clock samples the line, nine command bits first
  always @(posedge sclk) begin
    if (cs) begin
      if (n < 9) cmd = {cmd[7:0], din};
      else sh = {sh[14:0], din};
      n++;
      if (n == 9) cmd_log.push_back(cmd);
      if (n == 9 && cmd == 9'h130) en = 1'b1;
    end
  end

  // Read data leaves on the falling clock, MSB first
  always @(negedge sclk) begin
    if (cs && cmd[8:6] == 3'h6 && n >= 9 && n < 25) dout = mem[cmd[0]][24 - n];
  end

  // Enable is used up by one write, so every write needs its own
  always @(negedge cs) begin
    dout = ~dout; // Released line shows no stale value
    if (n == 25 && cmd[8:6] == 3'h5 && en) begin
      mem[cmd[0]] = sh;
      en = 1'b0;
      busy = 1'b1;
      #20000 busy = 1'b0;
    end
  end

  // Ready level shows while selected after programming
  always @(posedge cs) begin
    n = 0;
    if (busy) dout = 1'b0;
  end
  always @(negedge busy) begin
    if (cs) dout = 1'b1;
  end

  // Shift register part: load while low, shift on rise when enabled
  always @(negedge din) sr = SR_WORD;
  always @(posedge sclk) begin
    if (!cs && din) sr = sr >> 1;
  end
  assign sr_q = sr[0];
endmodule : pmi_eeprom_model

// ===== tb/tb_pmi_param_memory.sv
`timescale 1ns/1ns

`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end

// ------------------------------------------------------------
// Bench for the parameter memory port
// ------------------------------------------------------------
module tb_pmi_param_memory;
  import pmi_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sel = 1'b0;
  logic aca = 1'b0;
  logic typ = 1'b1;
  logic tef = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] par = 7'h00;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [6:0] pins, station_address;
  logic [15:0] reg_rdata, s;
  logic [8:0] c;
  logic cs, cs_oe, sck, sck_oe, so, so_oe, ack, brs, nak, ee_do, sr_q;
  int fail_count = 0;
  int tests_run = 0;
  int n_ack = 0;
  int n_nak = 0;
  int cyc;
  time t_ack, t_brs;

  // System clock, 50 ns period
  always #25 mclk = ~mclk;
  // Serial mode reuses the address pins for the memory wires
  assign pins = sel ? {typ, aca, so, sck, cs, typ ? ee_do : sr_q, 1'b0}
                    : par;

  pmi_param_memory #(.PROG_TIMEOUT(500)) pmi_param_memory_inst (
    .mclk(mclk), .nrst(nrst), .clk_en(1'b1),
    .serial_param_select(sel), .station_address_pins(pins),
    .param_memory_select(cs), .param_memory_select_oe(cs_oe),
    .param_serial_clock(sck), .param_serial_clock_oe(sck_oe),
    .param_serial_out(so), .param_serial_out_oe(so_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .telegram_error_free(tef), .station_address(station_address),
    .call_ack(ack), .baud_search_restart(brs),
    .negative_ack_response(nak)
  );
  pmi_eeprom_model pmi_eeprom_model_inst (
    .cs(cs), .sclk(sck), .din(so), .dout(ee_do), .sr_q(sr_q)
  );

  // Count answer pulses and note when they were seen
  always @(posedge mclk) begin
    if (ack) begin
      n_ack++;
      t_ack = $time;
    end
    if (brs) t_brs = $time;
    if (nak) n_nak++;
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 s = reg_rdata;
  endtask : rd

  // Poll a flag under a bound; cyc gives the cycles it took
  task automatic wait_clear(input int b);
    cyc = 4;
    rd(REG_STATUS);
    while (s[b] !== 1'b0 && cyc < 40000) begin
      rd(REG_STATUS);
      cyc += 2;
    end
    `CHK(s[b], 1'b0)
  endtask : wait_clear

  task automatic t_parallel;
    par <= 7'h5B;
    repeat (4) @(posedge mclk);
    #1 `CHK(station_address, 7'h5B)
    wr(REG_CTRL, 16'h0002);
    repeat (3) @(posedge mclk);
    `CHK(n_nak, 1)
    $display("parallel address done");
  endtask : t_parallel

  task automatic t_read;
    sel <= 1'b1;
    repeat (6) @(posedge mclk);
    #1 `CHK({cs_oe, sck_oe, so_oe, cs, sck, so}, 6'h38)
    rd(REG_STATUS);
    `CHK(s[3:2], 2'h3)
    for (int w = 0; w < 2; w++) begin
      wr(REG_CTRL, w ? 16'h0005 : 16'h0001);
      rd(REG_STATUS);
      `CHK(s[0], 1'b1)
      wait_clear(0);
      `CHK(cyc inside {[3990:4010]}, 1'b1)
      c = pmi_eeprom_model_inst.cmd_log.pop_front();
      `CHK(c, {OP_READ, 5'h00, w[0]})
      rd(REG_RDATA);
      `CHK(s, pmi_eeprom_model_inst.mem[w])
    end
    `CHK(station_address, pmi_eeprom_model_inst.mem[0][6:0])
    $display("memory read done");
  endtask : t_read

  task automatic t_write;
    tef <= 1'b0;
    wr(REG_WDATA, 16'h1111);
    tef <= 1'b1;
    rd(REG_WDATA);
    `CHK(s, WDATA_RST)
    wr(REG_WDATA, 16'h0042);
    wr(REG_CTRL, 16'h000A); // Lock set, power-on grant still open
    rd(REG_STATUS);
    `CHK(s[1], 1'b1)
    wait_clear(1);
    `CHK(pmi_eeprom_model_inst.busy, 1'b0)
    `CHK(t_brs - t_ack, 50)
    c = pmi_eeprom_model_inst.cmd_log.pop_front();
    `CHK(c, {OP_EWEN, ADR_EWEN})
    c = pmi_eeprom_model_inst.cmd_log.pop_front();
    `CHK(c, {OP_WRITE, ADR_WORD0})
    `CHK(pmi_eeprom_model_inst.cmd_log.size(), 0)
    `CHK(pmi_eeprom_model_inst.mem[0], 16'h0042)
    `CHK(station_address, 7'h42)
    $display("memory write done");
  endtask : t_write

  task automatic t_lock;
    wr(REG_WDATA, 16'h0033);
    wr(REG_CTRL, 16'h000A);
    rd(REG_STATUS);
    `CHK({s[5], s[1]}, 2'h0)
    `CHK(n_ack, 2)
    aca <= 1'b1;
    repeat (3) @(posedge mclk); // Allow pin crosses the synchroniser
    wr(REG_CTRL, 16'h000A);
    rd(REG_STATUS);
    `CHK(s[1], 1'b1)
    wait_clear(1);
    `CHK(station_address, 7'h33)
    $display("address lock done");
  endtask : t_lock

  task automatic t_shift;
    typ <= 1'b0;
    repeat (6) @(posedge mclk);
    wr(REG_CTRL, 16'h0002);
    repeat (3) @(posedge mclk);
    `CHK(n_nak, 2)
    rd(REG_STATUS);
    `CHK(s[2], 1'b0)
    wr(REG_CTRL, 16'h0001);
    wait_clear(0);
    `CHK(cyc inside {[1950:1975]}, 1'b1)
    rd(REG_RDATA);
    `CHK(s, 16'h1234)
    `CHK(station_address, 7'h25)
    $display("shift register type done");
  endtask : t_shift

  task automatic tally_and_finish;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Main sequence, reset held for three cycles
  initial begin
    repeat (3) @(posedge mclk);
    `CHK({cs, sck, so, station_address}, 10'h000)
    nrst <= 1'b1;
    t_parallel();
    t_read();
    t_write();
    t_lock();
    t_shift();
    tally_and_finish();
  end

  // Whole run needs about 1 ms; five gives ample margin
  initial begin
    #5_000_000;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_pmi_param_memory
